// ==== core/bcs_unit.v ====
`timescale 1ns/100ps
`default_nettype none
`include "bcs_regs.vh"
// ==========================================================================
// Branch, call and stack sequencer
module bcs_unit (
   input  wire        clk,
   input  wire        rst_b,
   input  wire        op_valid,
   input  wire [3:0]  op_code,
   input  wire        op_mod,
   input  wire [3:0]  op_cc,
   input  wire [3:0]  flags,
   input  wire [15:0] op_pc,
   input  wire [15:0] op_word,
   input  wire [7:0]  op_seg,
   input  wire [15:0] op_ind,
   input  wire [15:0] op_rel,
   input  wire [15:0] reg_val,
   input  wire [3:0]  bit_pos,
   input  wire [15:0] mem_rdata,
   output reg         busy,
   output reg  [15:0] pc_q,
   output reg  [7:0]  csp_q,
   output reg  [15:0] sp_q,
   output reg         mem_we,
   output reg         mem_re,
   output reg  [15:0] mem_addr,
   output reg  [15:0] mem_wdata,
   output reg         reg_we,
   output reg  [15:0] reg_wdata
);
   // ======================================================================
   // Sequencer states, one-hot
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_PUSH = 5'h02;
   localparam [4:0] S_PUSH2 = 5'h04;
   localparam [4:0] S_POPW = 5'h08;
   localparam [4:0] S_POP2 = 5'h10;

   wire        cc_true;
   reg  [4:0]  st_q;
   reg  [15:0] w1_q;
   reg  [15:0] w2_q;
   reg         two_q;
   reg  [15:0] tgt_q;
   reg  [7:0]  tseg_q;
   reg         jump_q;
   reg         segj_q;
   reg         popreg_q;
   reg         ldreg_q;
   reg  [15:0] ldval_q;

   // ======================================================================
   // Condition evaluation on the status flags
   bcs_cond u_cond (
      .cc      (op_cc),
      .flags   (flags),
      .cc_true (cc_true)
   );

   // ======================================================================
   // Next sequential address
   function [15:0] nxt;
      input [15:0] pc;
      input [15:0] len;
      begin
         nxt = pc + len;
      end
   endfunction

   // Call target by addressing kind
   function [15:0] call_tgt;
      input [3:0]  code;
      input [15:0] abs_a;
      input [15:0] ind_a;
      input [15:0] rel_a;
      begin
         case (code)
            `BCS_OP_CALL_ABS: call_tgt = abs_a;
            `BCS_OP_CALL_IND: call_tgt = ind_a;
            default:          call_tgt = rel_a;
         endcase
      end
   endfunction

   // Addressed bit and neighbouring stack slots
   wire [15:0] bitmask = 16'h0001 << bit_pos;
   wire        bitv    = |(reg_val & bitmask);
   wire [15:0] sp_dec  = sp_q - `BCS_WORD_STEP;
   wire [15:0] sp_inc  = sp_q + `BCS_WORD_STEP;

   // ======================================================================
   // Main sequencer
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         // Idle, stack at its reset top
         st_q <= S_IDLE;
         busy <= 1'b0;
         pc_q <= `BCS_ZERO16;
         csp_q <= `BCS_ZERO8;
         sp_q <= `BCS_SP_RST;
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         mem_addr <= `BCS_ZERO16;
         mem_wdata <= `BCS_ZERO16;
         reg_we <= 1'b0;
         reg_wdata <= `BCS_ZERO16;
         w1_q <= `BCS_ZERO16;
         w2_q <= `BCS_ZERO16;
         two_q <= 1'b0;
         tgt_q <= `BCS_ZERO16;
         tseg_q <= `BCS_ZERO8;
         jump_q <= 1'b0;
         segj_q <= 1'b0;
         popreg_q <= 1'b0;
         ldreg_q <= 1'b0;
         ldval_q <= `BCS_ZERO16;
      end else begin
         // Strobes default low and are raised again by each state that needs them
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         reg_we <= 1'b0;
         case (st_q)
            S_IDLE: begin
               busy <= 1'b0;
               if (op_valid) begin
                  jump_q <= 1'b0;
                  segj_q <= 1'b0;
                  ldreg_q <= 1'b0;
                  two_q <= 1'b0;
                  case (op_code)
                     `BCS_OP_JMP_ABS: begin
                        pc_q <= cc_true ? op_word : nxt(op_pc, `BCS_LEN_4);
                     end
                     `BCS_OP_JMP_IND: begin
                        pc_q <= cc_true ? op_ind : nxt(op_pc, `BCS_LEN_2);
                     end
                     `BCS_OP_JMP_REL: begin
                        pc_q <= nxt(op_pc, `BCS_LEN_2) + (cc_true ? op_rel : `BCS_ZERO16);
                     end
                     `BCS_OP_JMP_SEG: begin
                        csp_q <= op_seg;
                        pc_q <= op_word;
                     end
                     `BCS_OP_JB, `BCS_OP_JNB: begin
                        // Taken when bit matches the branch sense
                        if (bitv == (op_code == `BCS_OP_JB)) begin
                           pc_q <= nxt(op_pc, `BCS_LEN_4) + op_rel;
                           if (op_mod) begin
                              reg_we <= 1'b1;
                              reg_wdata <= (op_code == `BCS_OP_JB) ? (reg_val & ~bitmask)
                                                                   : (reg_val | bitmask);
                           end
                        end else begin
                           pc_q <= nxt(op_pc, `BCS_LEN_4);
                        end
                     end
                     `BCS_OP_CALL_ABS, `BCS_OP_CALL_IND, `BCS_OP_CALL_REL: begin
                        if (cc_true) begin
                           // Push return address, then jump
                           w1_q <= nxt(op_pc, `BCS_LEN_4);
                           tgt_q <= call_tgt(op_code, op_word, op_ind,
                                             nxt(op_pc, `BCS_LEN_4) + op_rel);
                           jump_q <= 1'b1;
                           busy <= 1'b1;
                           st_q <= S_PUSH;
                        end else begin
                           pc_q <= nxt(op_pc, `BCS_LEN_4);
                        end
                     end
                     `BCS_OP_CALL_SEG: begin
                        w1_q <= {`BCS_ZERO8, csp_q};
                        w2_q <= nxt(op_pc, `BCS_LEN_4);
                        two_q <= 1'b1;
                        tgt_q <= op_word;
                        tseg_q <= op_seg;
                        segj_q <= 1'b1;
                        jump_q <= 1'b1;
                        busy <= 1'b1;
                        st_q <= S_PUSH;
                     end
                     `BCS_OP_PUSH_THEN_CALL: begin
                        w1_q <= reg_val;
                        w2_q <= nxt(op_pc, `BCS_LEN_4);
                        two_q <= 1'b1;
                        tgt_q <= op_word;
                        jump_q <= 1'b1;
                        busy <= 1'b1;
                        st_q <= S_PUSH;
                     end
                     `BCS_OP_TRAP: begin
                        // Vector from trap number, return address pushed
                        w1_q <= {`BCS_ZERO8, csp_q};
                        w2_q <= nxt(op_pc, `BCS_LEN_2);
                        two_q <= 1'b1;
                        tgt_q <= op_word << `BCS_TRAP_SHIFT;
                        tseg_q <= `BCS_ZERO8;
                        segj_q <= 1'b1;
                        jump_q <= 1'b1;
                        busy <= 1'b1;
                        st_q <= S_PUSH;
                     end
                     `BCS_OP_PUSH: begin
                        w1_q <= reg_val;
                        pc_q <= nxt(op_pc, `BCS_LEN_2);
                        busy <= 1'b1;
                        st_q <= S_PUSH;
                     end
                     `BCS_OP_POP: begin
                        // op_mod selects return, with or without register pop
                        mem_re <= 1'b1;
                        mem_addr <= sp_q;
                        sp_q <= sp_inc;
                        popreg_q <= op_mod ? op_cc[0] : 1'b1;
                        jump_q <= op_mod;
                        if (!op_mod)
                           pc_q <= nxt(op_pc, `BCS_LEN_2);
                        busy <= 1'b1;
                        st_q <= S_POPW;
                     end
                     `BCS_OP_CONTEXT_SWITCH_OP: begin
                        w1_q <= reg_val;
                        ldreg_q <= 1'b1;
                        ldval_q <= op_word;
                        pc_q <= nxt(op_pc, `BCS_LEN_4);
                        busy <= 1'b1;
                        st_q <= S_PUSH;
                     end
                     default: begin
                        // No operation: pointer held at this instruction
                        pc_q <= op_pc;
                     end
                  endcase
               end
            end
            S_PUSH: begin
               // Pre-decrement push of first word
               sp_q <= sp_dec;
               mem_we <= 1'b1;
               mem_addr <= sp_dec;
               mem_wdata <= w1_q;
               if (two_q) begin
                  st_q <= S_PUSH2;
               end else begin
                  if (jump_q)
                     pc_q <= tgt_q;
                  if (ldreg_q) begin
                     reg_we <= 1'b1;
                     reg_wdata <= ldval_q;
                  end
                  busy <= 1'b0;
                  st_q <= S_IDLE;
               end
            end
            S_PUSH2: begin
               // Second word and transfer of control, in the same cycle
               sp_q <= sp_dec;
               mem_we <= 1'b1;
               mem_addr <= sp_dec;
               mem_wdata <= w2_q;
               pc_q <= tgt_q;
               if (segj_q)
                  csp_q <= tseg_q;
               busy <= 1'b0;
               st_q <= S_IDLE;
            end
            S_POPW: begin
               // Stack data must stand while the read strobe does
               if (jump_q) begin
                  pc_q <= mem_rdata;
                  if (popreg_q) begin
                     mem_re <= 1'b1;
                     mem_addr <= sp_q;
                     sp_q <= sp_inc;
                     st_q <= S_POP2;
                  end else begin
                     busy <= 1'b0;
                     st_q <= S_IDLE;
                  end
               end else begin
                  reg_we <= 1'b1;
                  reg_wdata <= mem_rdata;
                  busy <= 1'b0;
                  st_q <= S_IDLE;
               end
            end
            S_POP2: begin
               // Register restore of the popping return
               reg_we <= 1'b1;
               reg_wdata <= mem_rdata;
               busy <= 1'b0;
               st_q <= S_IDLE;
            end
            default: begin
               // Illegal state falls back to idle
               st_q <= S_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== core/bcs_regs.vh ====
`ifndef BCS_REGS_VH
`define BCS_REGS_VH
// ==========================================================================
// Operation codes presented by the decoder
`define BCS_OP_NOP        4'h0
`define BCS_OP_JMP_ABS    4'h1
`define BCS_OP_JMP_IND    4'h2
`define BCS_OP_JMP_REL    4'h3
`define BCS_OP_JMP_SEG    4'h4
`define BCS_OP_JB         4'h5
`define BCS_OP_JNB        4'h6
`define BCS_OP_CALL_ABS   4'h7
`define BCS_OP_CALL_IND   4'h8
`define BCS_OP_CALL_REL   4'h9
`define BCS_OP_CALL_SEG   4'hA
`define BCS_OP_PUSH_THEN_CALL      4'hB
`define BCS_OP_TRAP       4'hC
`define BCS_OP_PUSH       4'hD
`define BCS_OP_POP        4'hE
`define BCS_OP_CONTEXT_SWITCH_OP       4'hF
// Return uses the modifier bit of the pop opcode space
`define BCS_OP_RET        4'h0
// ==========================================================================
// Instruction lengths in bytes
`define BCS_LEN_2         16'h0002
`define BCS_LEN_4         16'h0004
// ==========================================================================
// Condition codes
`define BCS_CC_UC         4'h0
`define BCS_CC_Z          4'h1
`define BCS_CC_NZ         4'h2
`define BCS_CC_C          4'h3
`define BCS_CC_NC         4'h4
`define BCS_CC_N          4'h5
`define BCS_CC_NN         4'h6
`define BCS_CC_V          4'h7
`define BCS_CC_NV         4'h8
// Flag positions in the status word
`define BCS_FLG_N         0
`define BCS_FLG_C         1
`define BCS_FLG_V         2
`define BCS_FLG_Z         3
// ==========================================================================
// Reset values and stack step
`define BCS_SP_RST        16'hFC00
`define BCS_WORD_STEP     16'h0002
`define BCS_ZERO16        16'h0000
`define BCS_ZERO8         8'h00
`define BCS_TRAP_SHIFT    2
`endif

// ==== core/bcs_cond.v ====
`timescale 1ns/100ps
`default_nettype none
`include "bcs_regs.vh"
// ==========================================================================
// Condition evaluator on processor flags
module bcs_cond (
   input  wire [3:0] cc,
   input  wire [3:0] flags,
   output reg        cc_true
);
   // Flag mapping per condition code
   always @* begin
      case (cc)
         `BCS_CC_UC: cc_true = 1'b1;
         `BCS_CC_Z:  cc_true = flags[`BCS_FLG_Z];
         `BCS_CC_NZ: cc_true = ~flags[`BCS_FLG_Z];
         `BCS_CC_C:  cc_true = flags[`BCS_FLG_C];
         `BCS_CC_NC: cc_true = ~flags[`BCS_FLG_C];
         `BCS_CC_N:  cc_true = flags[`BCS_FLG_N];
         `BCS_CC_NN: cc_true = ~flags[`BCS_FLG_N];
         `BCS_CC_V:  cc_true = flags[`BCS_FLG_V];
         `BCS_CC_NV: cc_true = ~flags[`BCS_FLG_V];
         default:    cc_true = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ==== dv/bcs_unit_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bcs_regs.vh"
// ==========================================================================
// Port checker for the branch and stack unit
module bcs_unit_chk (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        op_valid,
   input wire logic [3:0]  op_code,
   input wire logic        op_mod,
   input wire logic [3:0]  op_cc,
   input wire logic [15:0] op_word,
   input wire logic [7:0]  op_seg,
   input wire logic [15:0] op_ind,
   input wire logic [15:0] reg_val,
   input wire logic [3:0]  bit_pos,
   input wire logic        busy,
   input wire logic [15:0] pc_q,
   input wire logic [7:0]  csp_q,
   input wire logic [15:0] sp_q,
   input wire logic        mem_we,
   input wire logic        mem_re,
   input wire logic [15:0] mem_wdata,
   input wire logic        reg_we,
   input wire logic [15:0] reg_wdata
);
   logic        tk;
   logic        bit_v;
   logic [15:0] tk_sp_q, tk_val_q, tk_word_q, clr_q, set_q;
   // Take strobe and addressed bit
   assign tk = op_valid & ~busy;
   assign bit_v = reg_val[bit_pos];
   // Operands captured at the take edge
   always @(posedge clk) begin
      if (tk) begin
         tk_sp_q   <= sp_q;
         tk_val_q  <= reg_val;
         tk_word_q <= op_word;
         clr_q     <= reg_val & ~(16'h0001 << bit_pos);
         set_q     <= reg_val | (16'h0001 << bit_pos);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_reset_state: assert property ($rose(rst_b) |->
      pc_q == 16'h0000 && csp_q == 8'h00 && sp_q == `BCS_SP_RST) else $error("bad reset state");
   chk_jump_abs: assert property (tk && op_code == `BCS_OP_JMP_ABS && op_cc == 4'h0
      |=> pc_q == $past(op_word)) else $error("absolute jump target wrong");
   chk_jump_ind: assert property (tk && op_code == `BCS_OP_JMP_IND && op_cc == 4'h0
      |=> pc_q == $past(op_ind)) else $error("indirect jump target wrong");
   chk_seg_jump: assert property (tk && op_code == `BCS_OP_JMP_SEG
      |=> csp_q == $past(op_seg) && pc_q == $past(op_word)) else $error("segment jump wrong");
   chk_bit_clear: assert property (tk && op_code == `BCS_OP_JB && op_mod && bit_v
      |=> reg_we && reg_wdata == clr_q) else $error("bit not cleared");
   chk_bit_set: assert property (tk && op_code == `BCS_OP_JNB && op_mod && !bit_v
      |=> reg_we && reg_wdata == set_q) else $error("bit not set");
   chk_bit_keep: assert property (tk && op_mod && (op_code == `BCS_OP_JB && !bit_v ||
      op_code == `BCS_OP_JNB && bit_v) |=> !reg_we) else $error("bit written when not taken");
   chk_push_data: assert property (tk && op_code == `BCS_OP_PUSH
      |-> ##[1:2] (mem_we && mem_wdata == tk_val_q)) else $error("push data wrong");
   chk_push_sp: assert property (tk && op_code == `BCS_OP_PUSH
      |-> ##[1:3] sp_q == tk_sp_q - 16'h0002) else $error("push stack step wrong");
   chk_ret_read: assert property (tk && op_code == `BCS_OP_POP && op_mod
      |-> ##[1:2] mem_re) else $error("return did not read stack");
   chk_context_switch_op_load: assert property (tk && op_code == `BCS_OP_CONTEXT_SWITCH_OP
      |-> ##[1:4] (reg_we && reg_wdata == tk_word_q)) else $error("context load wrong");
endmodule
bind bcs_unit bcs_unit_chk bcs_unit_chk_i (.clk, .rst_b, .op_valid, .op_code, .op_mod, .op_cc,
   .op_word, .op_seg, .op_ind, .reg_val, .bit_pos, .busy, .pc_q, .csp_q, .sp_q, .mem_we,
   .mem_re, .mem_wdata, .reg_we, .reg_wdata);
`default_nettype wire

// ==== dv/bcs_unit_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bcs_regs.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module bcs_unit_test;
   // ==========================================================================
   // Inputs, outputs and bench state
   logic        clk = 1'b0, rst_b = 1'b0, op_valid = 1'b0, op_mod = 1'b0;
   logic [3:0]  op_code = 4'h0, op_cc = 4'h0, flags = 4'h0, bit_pos = 4'h0;
   logic [7:0]  op_seg = 8'h00;
   logic [15:0] op_pc = 16'h0, op_word = 16'h0, op_ind = 16'h0, op_rel = 16'h0, reg_val = 16'h0;
   logic [15:0] mem_rdata;
   logic        busy, mem_we, mem_re, reg_we, t;
   logic [7:0]  csp_q;
   logic [15:0] pc_q, sp_q, mem_addr, mem_wdata, reg_wdata, fst_wd, lst_wd, lst_rg, esp, e, r;
   logic [15:0] mem [0:255];
   int          failures, check_count, wr_n, rg_n, seed, i;
   bcs_unit bcs_unit_i (.clk, .rst_b, .op_valid, .op_code, .op_mod, .op_cc, .flags, .op_pc,
      .op_word, .op_seg, .op_ind, .op_rel, .reg_val, .bit_pos, .mem_rdata, .busy, .pc_q,
      .csp_q, .sp_q, .mem_we, .mem_re, .mem_addr, .mem_wdata, .reg_we, .reg_wdata);
   // Clock
   always #12.5 clk = ~clk;
   // Stack read, standing in the cycle of the read strobe
   assign mem_rdata = mem_re ? mem[mem_addr[8:1]] : 16'h0000;
   // Stack memory and write monitor
   always @(posedge clk) begin
      if (mem_we) begin
         mem[mem_addr[8:1]] <= mem_wdata;
         if (wr_n == 0) fst_wd <= mem_wdata;
         lst_wd <= mem_wdata;
         wr_n <= wr_n + 1;
      end
      if (reg_we) begin
         lst_rg <= reg_wdata;
         rg_n <= rg_n + 1;
      end
   end
   // Condition from the status flags
   function automatic logic cond(input logic [3:0] c, input logic [3:0] f);
      case (c)
         `BCS_CC_Z:  return f[`BCS_FLG_Z];
         `BCS_CC_NZ: return !f[`BCS_FLG_Z];
         `BCS_CC_C:  return f[`BCS_FLG_C];
         `BCS_CC_NC: return !f[`BCS_FLG_C];
         `BCS_CC_N:  return f[`BCS_FLG_N];
         `BCS_CC_NN: return !f[`BCS_FLG_N];
         `BCS_CC_V:  return f[`BCS_FLG_V];
         `BCS_CC_NV: return !f[`BCS_FLG_V];
         default:    return 1'b1;
      endcase
   endfunction
   // Random operands
   task automatic rnd();
      op_pc   <= 16'($random(seed)) & 16'hFFFE;
      op_word <= 16'($random(seed)) & 16'hFFFE;
      op_ind  <= 16'($random(seed)) & 16'hFFFE;
      op_rel  <= 16'($random(seed)) & 16'hFFFE;
      op_seg  <= 8'($random(seed));
      reg_val <= 16'($random(seed));
      bit_pos <= 4'($random(seed));
      flags   <= 4'($random(seed));
   endtask
   // Present one operation and wait for the unit to go idle
   task automatic run(input logic [3:0] c, input logic m);
      int n;
      op_code  <= c;
      op_mod   <= m;
      op_valid <= 1'b1;
      wr_n = 0;
      rg_n = 0;
      @(posedge clk);
      op_valid <= 1'b0;
      n = 0;
      repeat (3) @(posedge clk);
      while (busy !== 1'b0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) failures++;
      @(posedge clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog
   initial begin
      #200000;
      failures++;
      print_verdict();
   end
   // ==========================================================================
   // Main sequence
   initial begin
      seed = 32'h13e3;
      esp = `BCS_SP_RST;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      `CHK({pc_q, csp_q, sp_q}, {16'h0000, 8'h00, `BCS_SP_RST})
      for (i = 0; i < 30; i++) begin
         rnd();
         op_cc <= (i < 6) ? 4'h0 : 4'($unsigned($random(seed)) % 9);
         run(`BCS_OP_JMP_ABS + 4'(i % 3), 1'b0);
         t = cond(op_cc, flags);
         e = (i % 3 == 0) ? (t ? op_word : op_pc + 16'h0004) : (i % 3 == 1) ?
            (t ? op_ind : op_pc + 16'h0002) : op_pc + 16'h0002 + (t ? op_rel : 16'h0000);
         `CHK(pc_q, e)
      end
      for (i = 0; i < 16; i++) begin
         rnd();
         run(i[0] ? `BCS_OP_JNB : `BCS_OP_JB, i[1]);
         t = reg_val[bit_pos] ^ i[0];
         e = i[0] ? reg_val | (16'h0001 << bit_pos) : reg_val & ~(16'h0001 << bit_pos);
         `CHK(pc_q, op_pc + 16'h0004 + (t ? op_rel : 16'h0000))
         `CHK(rg_n, (t && i[1]) ? 1 : 0)
         if (t && i[1]) `CHK(lst_rg, e)
      end
      rnd();
      run(`BCS_OP_JMP_SEG, 1'b0);
      `CHK({csp_q, pc_q}, {op_seg, op_word})
      // Call of each target kind, each undone by a return
      for (i = 0; i < 3; i++) begin
         rnd();
         op_cc <= `BCS_CC_UC;
         run(`BCS_OP_CALL_ABS + 4'(i), 1'b0);
         e = (i == 0) ? op_word : (i == 1) ? op_ind : op_pc + 16'h0004 + op_rel;
         `CHK({pc_q, sp_q, lst_wd}, {e, esp - 16'h0002, op_pc + 16'h0004})
         run(`BCS_OP_POP, 1'b1);
         `CHK({pc_q, sp_q}, {op_pc + 16'h0004, esp})
      end
      op_cc <= `BCS_CC_Z;
      flags <= 4'h0;
      run(`BCS_OP_CALL_ABS, 1'b0);
      `CHK({pc_q, sp_q, 8'(wr_n)}, {op_pc + 16'h0004, esp, 8'h00})
      // Push, context switch, pop, then call and popping return
      rnd();
      run(`BCS_OP_PUSH, 1'b0);
      `CHK({lst_wd, sp_q}, {reg_val, esp - 16'h0002})
      r = reg_val;
      rnd();
      run(`BCS_OP_CONTEXT_SWITCH_OP, 1'b0);
      `CHK({lst_wd, lst_rg, sp_q}, {reg_val, op_word, esp - 16'h0004})
      run(`BCS_OP_POP, 1'b0);
      `CHK({lst_rg, sp_q}, {reg_val, esp - 16'h0002})
      op_cc <= `BCS_CC_UC;
      run(`BCS_OP_CALL_ABS, 1'b0);
      op_cc <= 4'h1;
      run(`BCS_OP_POP, 1'b1);
      `CHK({pc_q, lst_rg, sp_q}, {op_pc + 16'h0004, r, esp})
      // Segment call, trap and push then call
      rnd();
      run(`BCS_OP_CALL_SEG, 1'b0);
      `CHK({pc_q, csp_q, sp_q}, {op_word, op_seg, esp - 16'h0004})
      `CHK(lst_wd, op_pc + 16'h0004)
      op_word <= 16'h001D;
      run(`BCS_OP_TRAP, 1'b0);
      `CHK({pc_q, csp_q, sp_q}, {16'h0074, 8'h00, esp - 16'h0008})
      `CHK({fst_wd, lst_wd}, {8'h00, op_seg, op_pc + 16'h0002})
      rnd();
      run(`BCS_OP_PUSH_THEN_CALL, 1'b0);
      `CHK({pc_q, sp_q, fst_wd}, {op_word, esp - 16'h000C, reg_val})
      print_verdict();
   end
endmodule
`default_nettype wire
